/* logic/otp_pkg.sv */
// constants and carriers for the one-time programmable memory register block
// assumes a 32-bit APB slave port on pclk and a macro whose outputs are asynchronous
package otp_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [11:0] REG_SELECT = 12'h000;
  localparam logic [11:0] REG_LOCK_A = 12'h004;
  localparam logic [11:0] REG_LOCK_B = 12'h008;
  localparam logic [11:0] REG_CTRL = 12'h00C;
  localparam logic [11:0] REG_ADDR = 12'h010;
  localparam logic [11:0] REG_STATUS = 12'h014;
  localparam logic [11:0] REG_SECURE = 12'h018;

  // unlock keys, written in order lock_a then lock_b
  localparam logic [31:0] KEY_A = 32'h0000_00A5;
  localparam logic [31:0] KEY_B = 32'h0000_005A;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_READ_PATH = 0;
  localparam int CTRL_PROGRAM_HV = 1;
  localparam int CTRL_PUMP = 2;
  localparam int CTRL_DATA_LATCH = 3;
  localparam int CTRL_BUF_CLEAR_N = 4;
  localparam int CTRL_WSTROBE_N = 5;
  localparam int CTRL_TEST_CMD = 6;
  localparam int CTRL_PROG_DATA = 7;
  localparam int STAT_LOCK = 8;
  localparam int STAT_VALID = 9;
  localparam int STAT_STANDBY = 10;
  localparam int SEC_VALID = 8;

  localparam int ADDR_W = 14;
  localparam int DATA_W = 8;
  localparam int TEST_BIT = 13;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 14'h0000;
  localparam logic [DATA_W-1:0] WORD_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] WORD_ONES = 8'hFF;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_FIRST = 2'b01,
    LK_ARMED = 2'b10
  } lock_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] cell_addr;
    logic block_select_n;
    logic test_cmd_latch_en;
    logic data_latch_en;
    logic program_hv_en;
    logic read_path_en;
    logic buffer_clear_n;
    logic write_strobe_n;
    logic pump_en;
    logic program_data;
  } macro_ctrl_t;

  localparam macro_ctrl_t CTRL_RESET = '{
    cell_addr: ADDR_ZERO, block_select_n: 1'b1, test_cmd_latch_en: 1'b0,
    data_latch_en: 1'b0, program_hv_en: 1'b0, read_path_en: 1'b0,
    buffer_clear_n: 1'b1, write_strobe_n: 1'b1, pump_en: 1'b0, program_data: 1'b0};

endpackage : otp_pkg

/* logic/sync_two_stage.sv */
// two-flop synchroniser for a bus of independent levels
// assumes each bit is a quasi-static level; no word coherence is promised
`timescale 1ns/1ps
`default_nettype none
module sync_two_stage #(
  parameter int WIDTH = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] first_stage;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_stage <= '0;
      sync_out <= '0;
    end else begin
      first_stage <= async_in;
      sync_out <= first_stage;
    end
  end

endmodule : sync_two_stage
`default_nettype wire

/* logic/otp_register_access.sv */
// APB register front end driving a one-time programmable memory macro pin by pin
// assumes presetn is already synchronised to pclk and released early, and that the
// macro read data and lock status are asynchronous levels
//
// Overview of operation
// - blank memory reads zero; program only ones
// - program one bit, read one byte
// - fourteen-bit address, top bit selects test
// - block select high holds macro in standby
// - data latch enable opens input buffers
// - buffer clear resets buffers; toggle before modes
// - lock status one means permanently read-only
// - every macro pin reached through registers
// - single clock domain only
// - reset synchronised outside, none added here
// - dedicated early-released reset
// - select write needs both locks in order
// - standby blocks control register writes
// - select zero forces secure word zero
// - select one defaults secure word ones
// - first address-zero read latched until reset
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module otp_register_access (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output otp_pkg::macro_ctrl_t macro_ctrl,
  input wire logic [7:0] otp_read_data,
  input wire logic otp_lock,
  input wire logic secure_val_sel,
  output logic [7:0] secure_mode_word,
  output logic secure_mode_valid
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    otp_pkg::macro_ctrl_t ctrl;
    otp_pkg::lock_state_t lock_state;
    logic [31:0] rdata;
    logic [7:0] captured;
    logic captured_valid;
  } state_t;

  state_t st;
  state_t next_st;
  logic [9:0] sync_q;
  logic [7:0] rd_s;
  logic lock_s;
  logic sel_s;
  logic setup;
  logic access;
  logic wr;
  logic rd;
  logic mapped;

  // macro outputs and the strap are not on pclk
  sync_two_stage #(.WIDTH(10)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({secure_val_sel, otp_lock, otp_read_data}),
    .sync_out(sync_q)
  );
  assign rd_s = sync_q[7:0];
  assign lock_s = sync_q[8];
  assign sel_s = sync_q[9];

  // ****************************************
  // bus decode
  // ****************************************
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign mapped = (paddr == otp_pkg::REG_SELECT) || (paddr == otp_pkg::REG_LOCK_A) ||
                  (paddr == otp_pkg::REG_LOCK_B) || (paddr == otp_pkg::REG_CTRL) ||
                  (paddr == otp_pkg::REG_ADDR) || (paddr == otp_pkg::REG_STATUS) ||
                  (paddr == otp_pkg::REG_SECURE);
  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = st.rdata;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;
    // read data prepared during setup so it leaves a flip-flop
    if (setup) begin
      case (paddr)
        otp_pkg::REG_SELECT: begin
          next_st.rdata = {31'h0000_0000, st.ctrl.block_select_n};
        end
        otp_pkg::REG_LOCK_A: begin
          next_st.rdata = {30'h0000_0000, st.lock_state};
        end
        otp_pkg::REG_CTRL: begin
          next_st.rdata = otp_pkg::RDATA_ZERO;
          next_st.rdata[otp_pkg::CTRL_READ_PATH] = st.ctrl.read_path_en;
          next_st.rdata[otp_pkg::CTRL_PROGRAM_HV] = st.ctrl.program_hv_en;
          next_st.rdata[otp_pkg::CTRL_PUMP] = st.ctrl.pump_en;
          next_st.rdata[otp_pkg::CTRL_DATA_LATCH] = st.ctrl.data_latch_en;
          next_st.rdata[otp_pkg::CTRL_BUF_CLEAR_N] = st.ctrl.buffer_clear_n;
          next_st.rdata[otp_pkg::CTRL_WSTROBE_N] = st.ctrl.write_strobe_n;
          next_st.rdata[otp_pkg::CTRL_TEST_CMD] = st.ctrl.test_cmd_latch_en;
          next_st.rdata[otp_pkg::CTRL_PROG_DATA] = st.ctrl.program_data;
        end
        otp_pkg::REG_ADDR: begin
          next_st.rdata = {18'h0_0000, st.ctrl.cell_addr};
        end
        otp_pkg::REG_STATUS: begin
          next_st.rdata = {24'h00_0000, rd_s};
          next_st.rdata[otp_pkg::STAT_LOCK] = lock_s;
          next_st.rdata[otp_pkg::STAT_VALID] = st.captured_valid;
          next_st.rdata[otp_pkg::STAT_STANDBY] = st.ctrl.block_select_n;
        end
        otp_pkg::REG_SECURE: begin
          next_st.rdata = {24'h00_0000, secure_mode_word};
          next_st.rdata[otp_pkg::SEC_VALID] = secure_mode_valid;
        end
        default: begin
          next_st.rdata = otp_pkg::RDATA_ZERO;
        end
      endcase
    end
    // unlock sequence: any other write breaks it
    if (wr) begin
      next_st.lock_state = otp_pkg::LK_IDLE;
      if (paddr == otp_pkg::REG_LOCK_A && pwdata == otp_pkg::KEY_A) begin
        next_st.lock_state = otp_pkg::LK_FIRST;
      end
      if (paddr == otp_pkg::REG_LOCK_B && pwdata == otp_pkg::KEY_B &&
          st.lock_state == otp_pkg::LK_FIRST) begin
        next_st.lock_state = otp_pkg::LK_ARMED;
      end
      if (paddr == otp_pkg::REG_SELECT && st.lock_state == otp_pkg::LK_ARMED) begin
        next_st.ctrl.block_select_n = pwdata[0];
      end
      // standby freezes every other control field
      if (!st.ctrl.block_select_n) begin
        if (paddr == otp_pkg::REG_CTRL) begin
          next_st.ctrl.read_path_en = pwdata[otp_pkg::CTRL_READ_PATH];
          next_st.ctrl.program_hv_en = pwdata[otp_pkg::CTRL_PROGRAM_HV];
          next_st.ctrl.pump_en = pwdata[otp_pkg::CTRL_PUMP];
          next_st.ctrl.data_latch_en = pwdata[otp_pkg::CTRL_DATA_LATCH];
          next_st.ctrl.buffer_clear_n = pwdata[otp_pkg::CTRL_BUF_CLEAR_N];
          next_st.ctrl.write_strobe_n = pwdata[otp_pkg::CTRL_WSTROBE_N];
          next_st.ctrl.test_cmd_latch_en = pwdata[otp_pkg::CTRL_TEST_CMD];
          next_st.ctrl.program_data = pwdata[otp_pkg::CTRL_PROG_DATA];
        end
        if (paddr == otp_pkg::REG_ADDR) begin
          next_st.ctrl.cell_addr = pwdata[otp_pkg::ADDR_W-1:0];
        end
      end
    end
    // first completed read of cell zero is kept until reset
    if (rd && paddr == otp_pkg::REG_STATUS && !st.captured_valid &&
        !st.ctrl.block_select_n && st.ctrl.read_path_en &&
        st.ctrl.cell_addr == otp_pkg::ADDR_ZERO) begin
      next_st.captured = rd_s;
      next_st.captured_valid = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.ctrl <= otp_pkg::CTRL_RESET;
      st.lock_state <= otp_pkg::LK_IDLE;
      st.rdata <= otp_pkg::RDATA_ZERO;
      st.captured <= otp_pkg::WORD_ZERO;
      st.captured_valid <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // macro pins and secure word
  // ****************************************
  always_comb begin
    macro_ctrl = st.ctrl;
    // standby: no read, no program, no strobe reaches the macro
    if (st.ctrl.block_select_n) begin
      macro_ctrl.read_path_en = 1'b0;
      macro_ctrl.program_hv_en = 1'b0;
      macro_ctrl.pump_en = 1'b0;
      macro_ctrl.write_strobe_n = 1'b1;
    end
    // a locked part only burns power if high voltage is left on
    if (lock_s) begin
      macro_ctrl.program_hv_en = 1'b0;
      macro_ctrl.pump_en = 1'b0;
    end
  end

  assign secure_mode_valid = st.captured_valid;
  assign secure_mode_word = !sel_s ? otp_pkg::WORD_ZERO :
                            st.captured_valid ? st.captured : otp_pkg::WORD_ONES;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_select_write;
    wr && paddr == otp_pkg::REG_SELECT;
  endsequence
  sequence s_ctrl_write;
    wr && (paddr == otp_pkg::REG_CTRL || paddr == otp_pkg::REG_ADDR);
  endsequence
  // unlock chain: each key write is one step
  sequence s_key_a;
    wr && paddr == otp_pkg::REG_LOCK_A && pwdata == otp_pkg::KEY_A;
  endsequence
  sequence s_key_b;
    wr && paddr == otp_pkg::REG_LOCK_B && pwdata == otp_pkg::KEY_B;
  endsequence
  sequence s_live_ctrl;
    wr && paddr == otp_pkg::REG_CTRL && !st.ctrl.block_select_n;
  endsequence
  sequence s_live_addr;
    wr && paddr == otp_pkg::REG_ADDR && !st.ctrl.block_select_n;
  endsequence

  // pin gating
  a_locked_no_hv: assert property (lock_s |->
      !macro_ctrl.program_hv_en && !macro_ctrl.pump_en)
    else $error("program or pump reached a locked macro");
  a_standby_quiet: assert property (st.ctrl.block_select_n |->
      !macro_ctrl.read_path_en && !macro_ctrl.program_hv_en && macro_ctrl.write_strobe_n)
    else $error("macro active during standby");
  a_standby_pump: assert property (st.ctrl.block_select_n |-> !macro_ctrl.pump_en)
    else $error("pump on during standby");

  // unlock chain and select guard
  a_select_guarded: assert property ((s_select_write and
      st.lock_state != otp_pkg::LK_ARMED) |=> $stable(st.ctrl.block_select_n))
    else $error("select changed without unlock");
  a_select_unlocked: assert property ((s_select_write and
      st.lock_state == otp_pkg::LK_ARMED) |=>
      st.ctrl.block_select_n == $past(pwdata[0]) && st.lock_state == otp_pkg::LK_IDLE)
    else $error("unlocked select write not taken");
  a_key_first: assert property (s_key_a |=> st.lock_state == otp_pkg::LK_FIRST)
    else $error("first key did not advance unlock");
  a_key_second: assert property ((s_key_b and
      st.lock_state == otp_pkg::LK_FIRST) |=> st.lock_state == otp_pkg::LK_ARMED)
    else $error("second key did not arm unlock");
  a_key_broken: assert property (wr && paddr != otp_pkg::REG_LOCK_A &&
      paddr != otp_pkg::REG_LOCK_B |=> st.lock_state == otp_pkg::LK_IDLE)
    else $error("stray write did not break unlock");

  // live control writes land at the access edge; standby freezes them
  a_standby_frozen: assert property ((s_ctrl_write and st.ctrl.block_select_n)
      |=> $stable(st.ctrl))
    else $error("control changed in standby");
  a_latch_taken: assert property (s_live_ctrl |=>
      st.ctrl.data_latch_en == $past(pwdata[otp_pkg::CTRL_DATA_LATCH]) &&
      st.ctrl.program_data == $past(pwdata[otp_pkg::CTRL_PROG_DATA]))
    else $error("latch or program data not taken");
  a_clear_taken: assert property (s_live_ctrl |=>
      st.ctrl.buffer_clear_n == $past(pwdata[otp_pkg::CTRL_BUF_CLEAR_N]))
    else $error("buffer clear not taken");
  a_addr_taken: assert property (s_live_addr |=>
      st.ctrl.cell_addr == $past(pwdata[otp_pkg::ADDR_W-1:0]))
    else $error("cell address not taken");

  // secure word and read-back
  a_secure_zero: assert property (!sel_s |-> secure_mode_word == otp_pkg::WORD_ZERO)
    else $error("secure word not forced to zero");
  a_secure_default: assert property (sel_s && !secure_mode_valid |->
      secure_mode_word == otp_pkg::WORD_ONES)
    else $error("secure word default not all ones");
  a_capture_hold: assert property (secure_mode_valid |=>
      secure_mode_valid && $stable(st.captured))
    else $error("latched secure byte changed");
  a_capture_first: assert property ((rd && paddr == otp_pkg::REG_STATUS &&
      !st.captured_valid && macro_ctrl.read_path_en &&
      st.ctrl.cell_addr == otp_pkg::ADDR_ZERO)
      |=> secure_mode_valid && st.captured == $past(rd_s))
    else $error("first cell zero read not latched");
  a_secure_read: assert property ((setup && paddr == otp_pkg::REG_SECURE) |=>
      prdata[7:0] == $past(secure_mode_word) &&
      prdata[otp_pkg::SEC_VALID] == $past(secure_mode_valid))
    else $error("secure register read wrong");
  a_status_lock: assert property ((setup && paddr == otp_pkg::REG_STATUS) |=>
      prdata[otp_pkg::STAT_LOCK] == $past(lock_s) && prdata[7:0] == $past(rd_s))
    else $error("status read lost lock or data");
  a_unmapped_zero: assert property (setup && !mapped |=> prdata == otp_pkg::RDATA_ZERO)
    else $error("unmapped read not zero");

endmodule : otp_register_access
`default_nettype wire

/* dv/otp_macro_model.sv */
// behavioural model of the one-time programmable memory macro
// assumes pins come straight from the register block; no analog timing
`timescale 1ns/1ps
`default_nettype none
module otp_macro_model (
  input wire otp_pkg::macro_ctrl_t ctrl,
  output logic [7:0] read_data,
  output logic lock
);
  logic [7:0] mem [0:1023];
  logic [7:0] hold;
  logic latched;
  logic drive;
  // ****************************************
  // array and programming
  // ****************************************
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 8'h00;
    end
    lock = 1'b0;
    latched = 1'b0;
    hold = 8'h00;
  end
  always @(*) begin
    if (!ctrl.buffer_clear_n) begin
      latched = 1'b0;
    end else if (ctrl.data_latch_en) begin
      latched = ctrl.program_data;
    end
  end
  always @(negedge ctrl.write_strobe_n) begin
    // one bit per strobe, only with pump and high voltage up
    if (!ctrl.block_select_n && ctrl.program_hv_en && ctrl.pump_en && !lock) begin
      if (ctrl.cell_addr[13]) begin
        lock = 1'b1;
      end else if (latched) begin
        mem[ctrl.cell_addr[12:3]][ctrl.cell_addr[2:0]] = 1'b1;
      end
    end
  end
  // ****************************************
  // read path
  // ****************************************
  assign drive = !ctrl.block_select_n && ctrl.read_path_en;
  always @(*) begin
    if (drive) begin
      hold = mem[ctrl.cell_addr[12:3]];
    end
  end
  // released bus shows the inverse, never a stale copy
  assign read_data = drive ? hold : ~hold;
endmodule : otp_macro_model
`default_nettype wire

/* dv/tb_otp_register_access.sv */
// self-checking bench for the register block with a macro model behind it
// assumes zero-wait APB and two-flop sync of macro outputs
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_otp_register_access;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, otp_lock, sel, valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] otp_read_data, word;
  otp_pkg::macro_ctrl_t macro_ctrl;
  int n_fail = 0;
  int num_checks = 0;
  otp_register_access i_otp_register_access (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .macro_ctrl(macro_ctrl),
    .otp_read_data(otp_read_data), .otp_lock(otp_lock), .secure_val_sel(sel),
    .secure_mode_word(word), .secure_mode_valid(valid));
  otp_macro_model i_otp_macro_model (.ctrl(macro_ctrl), .read_data(otp_read_data),
    .lock(otp_lock));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    // pins move in the update region of the access edge; look once they settle
    @(negedge pclk);
  endtask : wr
  task automatic read_byte(input logic [13:0] a, input logic [7:0] e);
    wr(otp_pkg::REG_ADDR, {18'h0, a});
    wr(otp_pkg::REG_CTRL, 32'h0000_0020);
    wr(otp_pkg::REG_CTRL, 32'h0000_0031);
    repeat (3) @(posedge pclk);
    apb(1'b0, otp_pkg::REG_STATUS, 32'h0);
    `CHK("read byte", e, rd[7:0])
  endtask : read_byte
  task automatic program_bit(input logic [13:0] a);
    wr(otp_pkg::REG_ADDR, {18'h0, a});
    wr(otp_pkg::REG_CTRL, 32'h0000_0020);
    wr(otp_pkg::REG_CTRL, 32'h0000_0030);
    wr(otp_pkg::REG_CTRL, 32'h0000_00BE);
    wr(otp_pkg::REG_CTRL, 32'h0000_009E);
    wr(otp_pkg::REG_CTRL, 32'h0000_00BE);
    wr(otp_pkg::REG_CTRL, 32'h0000_0030);
  endtask : program_bit
  // ****************************************
  // scenarios
  // ****************************************
  task automatic standby_scenario();
    `CHK("reset pins", otp_pkg::CTRL_RESET, macro_ctrl)
    `CHK("default word", 8'hFF, word)
    `CHK("valid at reset", 1'b0, valid)
    wr(otp_pkg::REG_CTRL, 32'h0000_0031);
    apb(1'b0, otp_pkg::REG_CTRL, 32'h0);
    `CHK("ctrl in standby", 32'h0000_0030, rd)
    `CHK("mapped err", 1'b0, err)
    `CHK("read path standby", 1'b0, macro_ctrl.read_path_en)
    apb(1'b0, 12'h01C, 32'h0);
    `CHK("unmapped data", 32'h0, rd)
    `CHK("unmapped err", 1'b1, err)
  endtask : standby_scenario
  task automatic unlock_scenario();
    wr(otp_pkg::REG_SELECT, 32'h0);
    `CHK("select no keys", 1'b1, macro_ctrl.block_select_n)
    wr(otp_pkg::REG_LOCK_B, otp_pkg::KEY_B);
    wr(otp_pkg::REG_LOCK_A, otp_pkg::KEY_A);
    wr(otp_pkg::REG_SELECT, 32'h0);
    `CHK("select wrong order", 1'b1, macro_ctrl.block_select_n)
    wr(otp_pkg::REG_LOCK_A, otp_pkg::KEY_A);
    wr(otp_pkg::REG_LOCK_B, otp_pkg::KEY_B);
    wr(otp_pkg::REG_SELECT, 32'h0);
    `CHK("select unlocked", 1'b0, macro_ctrl.block_select_n)
  endtask : unlock_scenario
  task automatic secure_scenario();
    program_bit(14'h0001);
    read_byte(14'h0000, 8'h02);
    @(posedge pclk);
    `CHK("captured word", 8'h02, word)
    `CHK("captured valid", 1'b1, valid)
    apb(1'b0, otp_pkg::REG_SECURE, 32'h0);
    `CHK("secure reg", 32'h0000_0102, rd)
    program_bit(14'h0000);
    read_byte(14'h0000, 8'h03);
    read_byte(14'h0008, 8'h00);
    `CHK("word kept", 8'h02, word)
  endtask : secure_scenario
  task automatic lock_scenario();
    wr(otp_pkg::REG_CTRL, 32'h0000_0036);
    `CHK("hv before lock", 1'b1, macro_ctrl.program_hv_en)
    wr(otp_pkg::REG_CTRL, 32'h0000_0070);
    `CHK("command latch", 1'b1, macro_ctrl.test_cmd_latch_en)
    program_bit(14'h2000);
    repeat (3) @(posedge pclk);
    apb(1'b0, otp_pkg::REG_STATUS, 32'h0);
    `CHK("lock status", 1'b1, rd[otp_pkg::STAT_LOCK])
    wr(otp_pkg::REG_CTRL, 32'h0000_0036);
    `CHK("hv locked", 1'b0, macro_ctrl.program_hv_en)
    `CHK("pump locked", 1'b0, macro_ctrl.pump_en)
    sel <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("word forced zero", 8'h00, word)
  endtask : lock_scenario
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sel = 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    standby_scenario();
    unlock_scenario();
    secure_scenario();
    lock_scenario();
    tally_and_finish();
  end
endmodule : tb_otp_register_access
`default_nettype wire
